// [logic/bbs_sequencer.sv]
// control and sequencing logic of the buck-boost converter
//
// Local design decisions: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
// Contract
// - lockout pauses conversion only, settings kept
// - input undervoltage fall is deglitched
// - recovery from lockout uses shortened soft-start
// - start-up waits fixed enable delay
// - fast-ramp bit selects current-clamped start
// - clamp released at near-target, ramp finishes
// - limit select bit picks low/high clamp
// - no fast ramp: follow reference, ramp field
// - clamp too low: current raised to track
// - enable pin and bit give device state
// - pin low resets registers; bit does not
// - code above limit saturates to maximum
// - fast scaling bit picks reference slew
// - modulation bit: power save or forced
// - discharge when pin low or bit zero (pin low clears the field, so only bit zero discharges)
// - discharge field off or three settings
// - reverse current only in forced modulation
// - input overvoltage suspends forced modulation
// - output overvoltage: stage off, nodes high-z
// - hiccup: on interval, off interval, restart
// - short gone at restart: normal regulation
// - over-temperature stops conversion until cleared
module bbs_sequencer #(
    parameter int unsigned EN_DELAY = bbs_pkg::EN_DELAY_CYC,
    parameter int unsigned DEGLITCH = bbs_pkg::DEGLITCH_CYC,
    parameter int unsigned HICCUP_ON = bbs_pkg::HICCUP_ON_CYC,
    parameter int unsigned HICCUP_OFF = bbs_pkg::HICCUP_OFF_CYC,
    parameter logic [7:0] CTRL1_DEFAULT = bbs_pkg::CTRL1_RESET
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic enable_pin,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input bbs_pkg::bbs_flags_type flags,
    input wire logic ramp_lagging,
    input wire logic ramp_done,
    output bbs_pkg::bbs_stage_type stage,
    output logic device_active,
    output logic iface_active
);
    // ------------------------------------------------------------------
    // registers; the enable pin acts as a second reset
    // ------------------------------------------------------------------
    logic [7:0] ctrl1_q;
    logic [7:0] vout_q;
    logic [7:0] ctrl2_q;
    logic [7:0] rdata_q;
    logic regs_clr;
    logic wr_c1;
    logic wr_vo;
    logic wr_c2;

    assign regs_clr = !rst_n || !enable_pin;
    assign wr_c1 = reg_write && reg_addr == bbs_pkg::OFS_CTRL1;
    assign wr_vo = reg_write && reg_addr == bbs_pkg::OFS_VOUT;
    assign wr_c2 = reg_write && reg_addr == bbs_pkg::OFS_CTRL2;

    // settings survive lockout, faults and a cleared enable bit
    always_ff @(posedge clk_sys) begin
        if (regs_clr) begin
            ctrl1_q <= CTRL1_DEFAULT;
            vout_q <= bbs_pkg::VCODE_RESET;
            ctrl2_q <= bbs_pkg::CTRL2_RESET;
        end else begin
            if (wr_c1) begin
                ctrl1_q <= reg_wdata & bbs_pkg::C1_MASK;
            end
            if (wr_vo) begin
                vout_q <= reg_wdata;
            end
            if (wr_c2) begin
                ctrl2_q <= reg_wdata;
            end
        end
    end

    // ------------------------------------------------------------------
    // read port: data one cycle after the strobe, else zero
    // ------------------------------------------------------------------
    logic [7:0] status_w;
    logic [7:0] rsel_w;
    bbs_pkg::bbs_state_type state_q;

    assign status_w = {2'h0, state_q};
    assign rsel_w = (reg_addr == bbs_pkg::OFS_CTRL1) ? ctrl1_q :
                    (reg_addr == bbs_pkg::OFS_VOUT) ? vout_q :
                    (reg_addr == bbs_pkg::OFS_CTRL2) ? ctrl2_q :
                    (reg_addr == bbs_pkg::OFS_STATUS) ? status_w : 8'h00;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= reg_read ? rsel_w : 8'h00;
        end
    end
    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------------
    // control decode
    // ------------------------------------------------------------------
    logic conv_en;
    logic hiccup_en;
    logic fast_ramp;
    logic forced_sel;
    logic [1:0] disch_cfg;
    logic want_on;

    assign conv_en = ctrl1_q[bbs_pkg::C1_CONV_EN];
    assign hiccup_en = ctrl1_q[bbs_pkg::C1_HICCUP];
    assign fast_ramp = ctrl2_q[bbs_pkg::C2_FAST_RAMP];
    assign forced_sel = ctrl2_q[bbs_pkg::C2_FORCED];
    assign disch_cfg = ctrl2_q[bbs_pkg::C2_DISCH_LSB +: 2];
    assign want_on = enable_pin && conv_en;
    assign device_active = want_on;
    assign iface_active = enable_pin;

    // ------------------------------------------------------------------
    // deglitch of the rising undervoltage flag
    // ------------------------------------------------------------------
    logic [31:0] dg_q;
    logic uv_q;

    // only a sustained dip latches lockout; recovery acts at once
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            dg_q <= 32'h0;
            uv_q <= 1'b0;
        end else if (!flags.in_uv) begin
            dg_q <= 32'h0;
            uv_q <= 1'b0;
        end else if (dg_q >= DEGLITCH - 1) begin
            uv_q <= 1'b1;
        end else begin
            dg_q <= dg_q + 32'h1;
        end
    end

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    logic [31:0] cnt_q;
    logic quick_q;
    logic hic_off_q;
    logic stop_w;

    // lockout and over-temperature only pause conversion
    assign stop_w = uv_q || flags.over_temp;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q <= bbs_pkg::ST_OFF;
            cnt_q <= 32'h0;
            quick_q <= 1'b0;
            hic_off_q <= 1'b0;
        end else begin
            unique case (state_q)
                bbs_pkg::ST_OFF: begin
                    cnt_q <= 32'h0;
                    quick_q <= 1'b0;
                    if (want_on && !stop_w) begin
                        state_q <= bbs_pkg::ST_DELAY;
                    end
                end
                bbs_pkg::ST_DELAY: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (!want_on) begin
                        state_q <= bbs_pkg::ST_OFF;
                    end else if (cnt_q >= EN_DELAY - 1) begin
                        cnt_q <= 32'h0;
                        state_q <= fast_ramp ? bbs_pkg::ST_CLAMP : bbs_pkg::ST_RAMP;
                    end
                end
                bbs_pkg::ST_CLAMP: begin
                    if (flags.out_near) begin
                        state_q <= bbs_pkg::ST_RAMP;
                    end
                end
                bbs_pkg::ST_RAMP: begin
                    if (ramp_done) begin
                        state_q <= bbs_pkg::ST_RUN;
                        quick_q <= 1'b0;
                    end
                end
                bbs_pkg::ST_RUN: begin
                    cnt_q <= 32'h0;
                end
                bbs_pkg::ST_HOLD: begin
                    cnt_q <= cnt_q + 32'h1;
                    if (hic_off_q && cnt_q >= HICCUP_OFF - 1) begin
                        hic_off_q <= 1'b0;
                        cnt_q <= 32'h0;
                        state_q <= fast_ramp ? bbs_pkg::ST_CLAMP : bbs_pkg::ST_RAMP;
                    end else if (!hic_off_q && !stop_w) begin
                        quick_q <= 1'b1;
                        cnt_q <= 32'h0;
                        state_q <= fast_ramp ? bbs_pkg::ST_CLAMP : bbs_pkg::ST_RAMP;
                    end
                end
            endcase
            // hiccup on-interval runs while a short persists
            if (state_q != bbs_pkg::ST_OFF && state_q != bbs_pkg::ST_DELAY &&
                state_q != bbs_pkg::ST_HOLD) begin
                if (hiccup_en && flags.short_det) begin
                    cnt_q <= cnt_q + 32'h1;
                    if (cnt_q >= HICCUP_ON - 1) begin
                        cnt_q <= 32'h0;
                        hic_off_q <= 1'b1;
                        state_q <= bbs_pkg::ST_HOLD;
                    end
                end else if (state_q == bbs_pkg::ST_RUN || state_q == bbs_pkg::ST_CLAMP) begin
                    cnt_q <= 32'h0;
                end
                if (stop_w) begin
                    state_q <= bbs_pkg::ST_HOLD;
                    hic_off_q <= 1'b0;
                end
            end
            if (!want_on) begin
                state_q <= bbs_pkg::ST_OFF;
                hic_off_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // power stage commands
    // ------------------------------------------------------------------
    logic running;
    logic forced_modulation_select_ok;

    assign running = state_q == bbs_pkg::ST_CLAMP || state_q == bbs_pkg::ST_RAMP ||
                     state_q == bbs_pkg::ST_RUN;
    assign forced_modulation_select_ok = forced_sel && !flags.in_ov;

    always_comb begin
        stage = '0;
        stage.switching = running && !flags.out_ov;
        stage.hiz = !running || flags.out_ov;
        stage.clamp_on = state_q == bbs_pkg::ST_CLAMP;
        stage.clamp_high = ctrl2_q[bbs_pkg::C2_CL_SEL];
        stage.ramp_boost = running && state_q != bbs_pkg::ST_RUN && ramp_lagging;
        stage.ref_ramp = state_q == bbs_pkg::ST_RAMP;
        stage.quick_start = quick_q;
        stage.ramp_time = ctrl2_q[bbs_pkg::C2_RAMP_LSB +: 3];
        stage.target_code = (vout_q > bbs_pkg::VCODE_MAX) ? bbs_pkg::VCODE_MAX : vout_q;
        stage.fast_slew = ctrl1_q[bbs_pkg::C1_FAST_DVS];
        stage.forced_pwm = forced_modulation_select_ok;
        stage.reverse_ok = forced_modulation_select_ok && running;
        stage.discharge = !want_on && disch_cfg != 2'h0;
        stage.discharge_cfg = disch_cfg;
    end

    // ------------------------------------------------------------------
    // checks
    // ------------------------------------------------------------------
    chk_ovp_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flags.out_ov |-> stage.hiz && !stage.switching) else $error("ovp not high-z");
    chk_rev_forced: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stage.reverse_ok |-> forced_sel && !flags.in_ov) else $error("reverse outside forced_modulation_select");
    chk_ivp_forced_modulation_select: assert property (@(posedge clk_sys) disable iff (!rst_n)
        flags.in_ov |-> !stage.forced_pwm) else $error("forced_modulation_select during ivp");
    chk_code_sat: assert property (@(posedge clk_sys) disable iff (!rst_n)
        vout_q > 8'hb4 |-> stage.target_code == 8'hb4) else $error("code not saturated");
    chk_disch_off: assert property (@(posedge clk_sys) disable iff (!rst_n)
        stage.discharge |-> !want_on && disch_cfg != 2'h0) else $error("bad discharge");
    chk_pin_reset: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !enable_pin |=> ctrl1_q == CTRL1_DEFAULT && vout_q == 8'h5c) else $error("regs kept");
    chk_off_state: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !want_on |=> state_q == bbs_pkg::ST_OFF) else $error("not off");
    chk_delay_first: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(running) && $past(state_q) == bbs_pkg::ST_DELAY |-> $past(cnt_q) >= EN_DELAY - 1)
        else $error("start before delay");
    chk_uv_glitch: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(flags.in_uv) |=> !uv_q) else $error("lockout not deglitched");
    chk_uv_keep: assert property (@(posedge clk_sys) disable iff (!rst_n || !enable_pin)
        uv_q && !wr_vo |=> $stable(vout_q)) else $error("lockout touched settings");

    cov_fast: cover property (@(posedge clk_sys) state_q == bbs_pkg::ST_CLAMP ##1 state_q == bbs_pkg::ST_RAMP);
    cov_run: cover property (@(posedge clk_sys) state_q == bbs_pkg::ST_RUN);
    cov_hic: cover property (@(posedge clk_sys) hic_off_q);
    cov_quick: cover property (@(posedge clk_sys) quick_q && running);
endmodule

// [logic/bbs_pkg.sv]
// shared constants and types of the buck-boost control sequencer
package bbs_pkg;
    // ------------------------------------------------------------------
    // clock and times
    // ------------------------------------------------------------------
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned EN_DELAY_US = 100;
    localparam int unsigned DEGLITCH_US = 10;
    localparam int unsigned HICCUP_ON_MS = 9;
    localparam int unsigned HICCUP_OFF_MS = 22;
    localparam int unsigned EN_DELAY_CYC = EN_DELAY_US * CLK_MHZ;
    localparam int unsigned DEGLITCH_CYC = DEGLITCH_US * CLK_MHZ;
    localparam int unsigned HICCUP_ON_CYC = HICCUP_ON_MS * 1000 * CLK_MHZ;
    localparam int unsigned HICCUP_OFF_CYC = HICCUP_OFF_MS * 1000 * CLK_MHZ;

    // ------------------------------------------------------------------
    // output-voltage code and register reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] VCODE_MAX = 8'hb4;
    localparam logic [7:0] VCODE_RESET = 8'h5c;
    localparam logic [7:0] VCODE_DEFAULT_RESET = 8'h5c;
    localparam logic [7:0] CTRL1_RESET = 8'h08;
    localparam logic [7:0] CTRL2_RESET = 8'h00;

    // ------------------------------------------------------------------
    // register offsets (own map; no bus supplied by the pins)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL1 = 8'h02;
    localparam logic [7:0] OFS_VOUT = 8'h03;
    localparam logic [7:0] OFS_CTRL2 = 8'h05;
    localparam logic [7:0] OFS_STATUS = 8'h06;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int unsigned C1_CONV_EN = 0;
    localparam int unsigned C1_HICCUP = 2;
    localparam int unsigned C1_FAST_DVS = 3;
    localparam logic [7:0] C1_MASK = 8'h0d;
    localparam int unsigned C2_FAST_RAMP = 0;
    localparam int unsigned C2_CL_SEL = 1;
    localparam int unsigned C2_RAMP_LSB = 2;
    localparam int unsigned C2_FORCED = 5;
    localparam int unsigned C2_DISCH_LSB = 6;

    // ------------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_DELAY = 6'h02,
        ST_CLAMP = 6'h04,
        ST_RAMP = 6'h08,
        ST_RUN = 6'h10,
        ST_HOLD = 6'h20
    } bbs_state_type;

    // analog comparator flags
    typedef struct packed {
        logic in_uv;
        logic in_ov;
        logic out_ov;
        logic out_near;
        logic short_det;
        logic over_temp;
    } bbs_flags_type;

    // commands to the power stage
    typedef struct packed {
        logic switching;
        logic hiz;
        logic clamp_on;
        logic clamp_high;
        logic ramp_boost;
        logic ref_ramp;
        logic quick_start;
        logic [2:0] ramp_time;
        logic [7:0] target_code;
        logic fast_slew;
        logic forced_pwm;
        logic reverse_ok;
        logic discharge;
        logic [1:0] discharge_cfg;
    } bbs_stage_type;
endpackage

// [dv/bbs_stage_model.sv]
// behavioural power stage and comparators facing the sequencer
`timescale 1ns/1ps
module bbs_stage_model (
    input wire logic clk_sys,
    input wire logic rst_n,
    input bbs_pkg::bbs_stage_type stage,
    input wire logic [4:0] fault,
    input wire logic lag,
    output bbs_pkg::bbs_flags_type flags,
    output logic ramp_lagging,
    output logic ramp_done
);
    // ------------------------------------------------------------------
    // output build-up
    // ------------------------------------------------------------------
    logic [7:0] run_q;
    // output only builds while switching; any stop drops it back to zero
    always_ff @(posedge clk_sys) begin
        if (!rst_n || !stage.switching) begin
            run_q <= 8'h00;
        end else if (run_q != 8'hff) begin
            run_q <= run_q + 8'h01;
        end
    end
    // ------------------------------------------------------------------
    // comparators
    // ------------------------------------------------------------------
    // faults come from the bench; near-target after a few switching cycles
    assign flags = {fault[4:2], run_q > 8'h03, fault[1:0]};
    assign ramp_lagging = lag & stage.ref_ramp; // only meaningful while ramping
    assign ramp_done = stage.ref_ramp & (run_q > 8'h06);
endmodule

// [dv/tb.sv]
// self-checking bench of the buck-boost control sequencer
`timescale 1ns/1ps
module tb;
    localparam int EN_DLY = 4;
    localparam int HIC_ON = 10;
    localparam int HIC_OFF = 20;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic enable_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [4:0] fault = 5'h00;
    logic lag = 1'b0;
    logic [7:0] reg_rdata;
    bbs_pkg::bbs_flags_type flags;
    logic ramp_lagging;
    logic ramp_done;
    bbs_pkg::bbs_stage_type stage;
    logic device_active;
    logic iface_active;
    logic [7:0] w;
    logic [7:0] rv;
    int fail_count = 0;
    int compares = 0;
    int cycles = 0;
    int n;
    int f;
    int mreg[3]; // model of ctrl1, vout, ctrl2
    logic [7:0] codes[$];

    bbs_sequencer #(.EN_DELAY(EN_DLY), .DEGLITCH(4), .HICCUP_ON(HIC_ON), .HICCUP_OFF(HIC_OFF)) dut (
        .clk_sys(clk_sys), .rst_n(rst_n), .enable_pin(enable_pin), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .flags(flags), .ramp_lagging(ramp_lagging), .ramp_done(ramp_done), .stage(stage),
        .device_active(device_active), .iface_active(iface_active));
    bbs_stage_model stg (.clk_sys(clk_sys), .rst_n(rst_n), .stage(stage), .fault(fault), .lag(lag),
        .flags(flags), .ramp_lagging(ramp_lagging), .ramp_done(ramp_done));

    // watched stage bits, indexed by the wait task
    assign w = {stage.switching, stage.clamp_on, stage.quick_start, stage.hiz, stage.ramp_boost,
        stage.ref_ramp, stage.clamp_high, 1'b0};

    always #2 clk_sys = ~clk_sys;

    // hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // writes are ignored while the enable pin is low, so the model is too
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (enable_pin === 1'b1 && a == 8'h02) mreg[0] = d & 8'h0d;
        if (enable_pin === 1'b1 && a == 8'h03) mreg[1] = d;
        if (enable_pin === 1'b1 && a == 8'h05) mreg[2] = d;
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [7:0] a);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        #1 rv = reg_rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a);
        rd(a);
        chk(rv, a == 8'h02 ? 8'(mreg[0]) : a == 8'h03 ? 8'(mreg[1]) : a == 8'h05 ? 8'(mreg[2]) : 8'h00);
    endtask

    // bounded wait for a watched bit, then compare it
    task automatic waitb(input int idx, input logic v, input int lim);
        n = 0;
        while (w[idx] !== v && n < lim) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk({7'h00, w[idx]}, {7'h00, v});
    endtask

    task automatic stage_chk();
        f = ((mreg[2] >> 5) & 1) & !fault[3];
        chk(stage.target_code, mreg[1] > 'hb4 ? 8'hb4 : 8'(mreg[1]));
        chk({7'h00, stage.fast_slew}, 8'((mreg[0] >> 3) & 1));
        // reverse current is expected only with forced modulation selected, no input overvoltage, and the enable pin and the conversion bit both set
        chk({6'h00, stage.forced_pwm, stage.reverse_ok}, 8'(f * 2 + (f & enable_pin & mreg[0][0])));
        chk({3'h0, stage.ramp_time, stage.discharge_cfg}, 8'(((mreg[2] >> 2) & 7) * 4 + (mreg[2] >> 6)));
        chk({7'h00, stage.discharge}, 8'((mreg[2] >> 6) != 0 && !(enable_pin && (mreg[0] & 1))));
        chk({6'h00, iface_active, device_active}, {6'h00, enable_pin, enable_pin & mreg[0][0]});
    endtask

    // ------------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------------
    initial begin
        void'($urandom(32'heed2));
        mreg = '{8, 92, 0};
        repeat (8) @(posedge clk_sys);
        rst_n <= 1'b1;
        enable_pin <= 1'b1;
        @(posedge clk_sys);
        foreach (codes[i]) codes.delete();
        for (int a = 2; a < 8; a++) if (a != 6) rd_chk(8'(a));
        rd(8'h06);
        chk(rv, 8'h01);
        wr(8'h02, 8'hf2);
        rd_chk(8'h02);
        $display("register defaults done");
        codes = '{8'h00, 8'hb4, 8'hb5, 8'hff};
        repeat (6) codes.push_back(8'($urandom));
        foreach (codes[i]) begin
            fault[3] <= 1'($urandom);
            wr(8'h03, codes[i]);
            wr(8'h05, 8'($urandom));
            wr(8'h02, 8'($urandom) & 8'hfe); // converter held off so the decode is static
            rd_chk(8'h03);
            stage_chk();
        end
        fault[3] <= 1'b0;
        enable_pin <= 1'b0;
        @(posedge clk_sys);
        mreg = '{8, 92, 0};
        wr(8'h03, 8'h11);
        stage_chk();
        enable_pin <= 1'b1;
        @(posedge clk_sys);
        rd_chk(8'h03);
        $display("configuration decode done");
        wr(8'h05, 8'h03);
        wr(8'h02, 8'h09);
        waitb(7, 1'b1, 40);
        chk(8'(n >= EN_DLY), 8'h01);
        chk({6'h00, w[6], w[1]}, 8'h03);
        waitb(6, 1'b0, 20);
        chk({7'h00, w[2]}, 8'h01);
        lag <= 1'b1;
        waitb(3, 1'b1, 4);
        lag <= 1'b0;
        repeat (12) @(posedge clk_sys);
        rd(8'h06);
        chk(rv, 8'h10);
        $display("fast start-up done");
        fault[4] <= 1'b1;
        repeat (2) @(posedge clk_sys);
        fault[4] <= 1'b0;
        repeat (3) @(posedge clk_sys);
        #1 chk({7'h00, w[7]}, 8'h01);
        fault[4] <= 1'b1;
        waitb(7, 1'b0, 12);
        rd_chk(8'h05);
        fault[4] <= 1'b0;
        waitb(5, 1'b1, 10);
        repeat (20) @(posedge clk_sys);
        fault[0] <= 1'b1;
        waitb(7, 1'b0, 4);
        fault[0] <= 1'b0;
        waitb(7, 1'b1, 10);
        fault[2] <= 1'b1;
        waitb(4, 1'b1, 4);
        chk({7'h00, w[7]}, 8'h00);
        fault[2] <= 1'b0;
        waitb(4, 1'b0, 4);
        $display("lockout and fault responses done");
        wr(8'h02, 8'h0d);
        repeat (20) @(posedge clk_sys);
        fault[1] <= 1'b1;
        waitb(7, 1'b0, HIC_ON + 8);
        chk(8'(n >= HIC_ON - 1), 8'h01);
        waitb(7, 1'b1, HIC_OFF + 8);
        chk(8'(n >= HIC_OFF - 1), 8'h01);
        fault[1] <= 1'b0;
        repeat (HIC_ON + HIC_OFF) @(posedge clk_sys);
        #1 chk({7'h00, w[7]}, 8'h01);
        $display("hiccup done");
        enable_pin <= 1'b0;
        repeat (2) @(posedge clk_sys);
        mreg = '{8, 92, 0};
        enable_pin <= 1'b1;
        @(posedge clk_sys);
        wr(8'h05, 8'h30);
        wr(8'h02, 8'h01);
        waitb(7, 1'b1, 20);
        chk({6'h00, w[6], w[2]}, 8'h01);
        stage_chk();
        $display("reference ramp start-up done");
        print_verdict();
    end
endmodule
